// ### rpq_pkg.sv
/*
  Package for the dual-parity engine: field constants, operation codes,
  sizes and reset values shared by the engine and its testbench.
  Assumes a byte-wide finite field with generator polynomial 0x11D.
*/
package rpq_pkg;
  localparam int          BYTE_W        = 8;
  localparam int          POS_W         = 8;
  localparam logic [8:0]  FIELD_POLY    = 9'h11D;
  localparam logic [8:0]  FIELD_ORDER   = 9'h0FF;
  localparam logic [7:0]  MAX_DISKS     = 8'hFF;
  localparam logic [7:0]  MAX_DATA_POS  = 8'hFC;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [7:0]  ONE_BYTE      = 8'h01;
  localparam int          PIPE_LAT      = 2;

  typedef enum logic [1:0] {
    RPQ_OP_GEN    = 2'b00,
    RPQ_OP_UPDATE = 2'b01,
    RPQ_OP_REGEN  = 2'b10,
    RPQ_OP_MUL    = 2'b11
  } rpq_op_t;
endpackage

// ### rpq_parity_engine.sv
/*
  Byte-serial dual-parity engine: accumulates P and Q over a stripe,
  updates parity from old and new data, rebuilds one lost data block.
  Assumes the buffer controller streams one byte a cycle with the
  data position of that byte, and that firmware sequences the stripes.
*/
// Summary of operation
// - Q is XOR of each data byte times its position coefficient.
// - coefficient of position i is antilog of i; position three gives 0x8.
// - positions zero, one and two weigh by 0x01, 0x02 and 0x04.
// - coefficient follows stripe position, never the physical drive.
// - updated P is old P XOR old data XOR new data.
// - updated Q is old Q XOR coefficient times (old XOR new data).
// - lost data block is XOR of surviving data and P.
// - P uses data bytes and, on update, old P; XOR only, no field multiply.
// - field multiply adds logs modulo 255, then looks up antilog.
// - zero operands bypass the log table, which has no zero entry.
// - up to 255 disks, two of them parity, so data positions 0 to 252.
`timescale 1ns/1ps
module rpq_parity_engine (
  input  wire logic                      ref_clk,     // 250 MHz clock
  input  wire logic                      srst,        // sync reset, high
  input  wire logic                      inValid,     // byte offered
  output logic                           inReady,     // byte accepted
  input  wire logic [1:0]                opCode,      // rpq_op_t
  input  wire logic                      firstByte,   // first byte of sector column
  input  wire logic                      lastByte,    // last byte of sector column
  input  wire logic [7:0]                dataPos,     // stripe data position
  input  wire logic [7:0]                dataByte,    // data or new data
  input  wire logic [7:0]                oldByte,     // old data (update)
  input  wire logic [7:0]                oldP,        // old P (update)
  input  wire logic [7:0]                oldQ,        // old Q (update)
  output logic                           outValid,    // result pulse
  output logic [7:0]                     outP,        // P or rebuilt data
  output logic [7:0]                     outQ,        // Q or product
  output logic                           posError     // position out of range
);
  // full field tables, built once at elaboration
  function automatic logic [7:0] fAlog(input logic [7:0] idx);
    logic [8:0] v;
    v = 9'h001;
    for (int k = 0; k < 255; k++) begin
      if (k[7:0] == idx) begin
        return v[7:0];
      end
      v = {v[7:0], 1'b0};
      if (v[8]) begin
        v = v ^ rpq_pkg::FIELD_POLY;
      end
    end
    return 8'h00;
  endfunction

  // inverse table by search; costly only once, at time zero
  function automatic logic [7:0] fLog(input logic [7:0] val);
    logic [8:0] v;
    v = 9'h001;
    for (int k = 0; k < 255; k++) begin
      if (v[7:0] == val) begin
        return k[7:0];
      end
      v = {v[7:0], 1'b0};
      if (v[8]) begin
        v = v ^ rpq_pkg::FIELD_POLY;
      end
    end
    // zero has no logarithm; the multiplier never uses this entry
    return 8'h00;
  endfunction

  logic [7:0] alogTab [0:255];
  logic [7:0] logTab  [0:255];
  generate
    for (genvar g = 0; g < 256; g++) begin : gTab
      assign alogTab[g] = fAlog(8'(g));
      assign logTab[g]  = fLog(8'(g));
    end
  endgenerate

  // field multiply via log add then antilog; zero operands bypass the table
  function automatic logic [7:0] gfMul(input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] la, input logic [7:0] lb,
                                       input logic [7:0] al [0:255]);
    logic [8:0] s;
    s = {1'b0, la} + {1'b0, lb};
    if (s >= rpq_pkg::FIELD_ORDER) begin
      s = s - rpq_pkg::FIELD_ORDER;
    end
    if (a == rpq_pkg::ZERO_BYTE || b == rpq_pkg::ZERO_BYTE) begin
      return rpq_pkg::ZERO_BYTE;
    end
    return al[s[7:0]];
  endfunction

  rpq_pkg::rpq_op_t op;
  assign op = rpq_pkg::rpq_op_t'(opCode);
  // no back-pressure: one byte a cycle, every cycle
  assign inReady = 1'b1;

  wire        take     = inValid & inReady;
  // out-of-range positions still compute; only the flag warns firmware
  wire        posOk    = (dataPos <= rpq_pkg::MAX_DATA_POS);
  // coefficient indexed by stripe position, not drive number
  wire [7:0]  coef     = alogTab[dataPos];
  wire        isUpd    = (op == rpq_pkg::RPQ_OP_UPDATE);
  wire        isMul    = (op == rpq_pkg::RPQ_OP_MUL);
  wire [7:0]  diffByte = oldByte ^ dataByte;
  // update multiplies the change of the data, so unchanged bytes leave Q alone
  wire [7:0]  mulOp    = isUpd ? diffByte : dataByte;
  wire [7:0]  mulB     = isMul ? oldByte : coef;
  // update: old P and data diff; gen and regen: XOR only, no multiply
  wire [7:0]  pinSel   = isUpd ? (oldP ^ diffByte) : dataByte;

  // stage 1: register operands and logs so the adder sees a short path
  logic       s1Valid_r;
  logic       s1First_r;
  logic       s1Last_r;
  logic       s1Err_r;
  logic [1:0] s1Op_r;
  logic [7:0] s1A_r;
  logic [7:0] s1B_r;
  logic [7:0] s1LA_r;
  logic [7:0] s1LB_r;
  logic [7:0] s1Pin_r;
  logic [7:0] s1Qin_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1Valid_r <= 1'b0;
      s1First_r <= 1'b0;
      s1Last_r  <= 1'b0;
      s1Err_r   <= 1'b0;
      s1Op_r    <= 2'b00;
      s1A_r     <= 8'h00;
      s1B_r     <= 8'h00;
      s1LA_r    <= 8'h00;
      s1LB_r    <= 8'h00;
      s1Pin_r   <= 8'h00;
      s1Qin_r   <= 8'h00;
    end else begin
      s1Valid_r <= take;
      if (take) begin
        s1First_r <= firstByte;
        s1Last_r  <= lastByte;
        s1Err_r   <= ~posOk && ~isMul;
        s1Op_r    <= opCode;
        s1A_r     <= mulOp;
        s1B_r     <= mulB;
        s1LA_r    <= logTab[mulOp];
        s1LB_r    <= logTab[mulB];
        s1Pin_r   <= pinSel;
        s1Qin_r   <= oldQ;
      end
    end
  end

  // stage 2 sees registered logs, so the add and table read fit one cycle
  wire [7:0] prod = gfMul(s1A_r, s1B_r, s1LA_r, s1LB_r, alogTab);

  // stage 2: accumulators for a sector column across the stripe
  logic [7:0] accP_r;
  logic [7:0] accQ_r;
  logic [7:0] accP_nxt;
  logic [7:0] accQ_nxt;
  logic       errAcc_r;

  // a first byte restarts the column so stale sums never leak across stripes
  assign accP_nxt = (s1First_r ? rpq_pkg::ZERO_BYTE : accP_r) ^ s1Pin_r;
  assign accQ_nxt = (s1First_r ? rpq_pkg::ZERO_BYTE : accQ_r) ^ prod;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // outputs clear with the pipe, so a cut column leaves no result
      accP_r   <= 8'h00;
      accQ_r   <= 8'h00;
      errAcc_r <= 1'b0;
      outValid <= 1'b0;
      outP     <= 8'h00;
      outQ     <= 8'h00;
      posError <= 1'b0;
    end else begin
      outValid <= 1'b0;
      if (s1Valid_r) begin
        unique case (rpq_pkg::rpq_op_t'(s1Op_r))
          // regen shares the column path: rebuilt data leaves on outP
          rpq_pkg::RPQ_OP_GEN, rpq_pkg::RPQ_OP_REGEN: begin
            accP_r   <= accP_nxt;
            accQ_r   <= accQ_nxt;
            errAcc_r <= (s1First_r ? 1'b0 : errAcc_r) | s1Err_r;
            if (s1Last_r) begin
              outValid <= 1'b1;
              outP     <= accP_nxt;
              outQ     <= accQ_nxt;
              posError <= (s1First_r ? 1'b0 : errAcc_r) | s1Err_r;
            end
          end
          // one byte in, one result out; no column framing
          rpq_pkg::RPQ_OP_UPDATE: begin
            outValid <= 1'b1;
            outP     <= s1Pin_r;
            outQ     <= s1Qin_r ^ prod;
            posError <= s1Err_r;
          end
          // test path: lets firmware check the table multiply directly
          rpq_pkg::RPQ_OP_MUL: begin
            outValid <= 1'b1;
            outP     <= s1A_r ^ s1B_r;
            outQ     <= prod;
            posError <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// ### rpq_engine_sva.sv
/* port checks for the parity engine.
   assumes single clock, sync reset high */
`timescale 1ns/1ps
module rpq_engine_sva (
  input wire logic       ref_clk,   // clk
  input wire logic       srst,      // rst
  input wire logic       inValid,   // vld
  input wire logic [1:0] opCode,    // op
  input wire logic       firstByte, // first
  input wire logic       lastByte,  // last
  input wire logic [7:0] dataPos,   // pos
  input wire logic [7:0] dataByte,  // data
  input wire logic [7:0] oldByte,   // old
  input wire logic [7:0] oldP,      // old p
  input wire logic       outValid,  // done
  input wire logic [7:0] outP,      // p
  input wire logic [7:0] outQ,      // q
  input wire logic       posError   // err
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence sOne(op);
    inValid && firstByte && lastByte && opCode == op;
  endsequence
  sequence sMul;
    inValid && opCode == 2'h3;
  endsequence
  sequence sUpd;
    inValid && opCode == 2'h1;
  endsequence
  sequence sColEnd;
    inValid && lastByte && !opCode[0];
  endsequence
  AST_LAT: assert property (inValid && opCode[0] |-> ##2 outValid)
    else $error("late result");
  AST_MUL0: assert property (sMul ##0 (dataByte == 0 || oldByte == 0) |-> ##2 outQ == 0)
    else $error("zero product");
  AST_MUL1: assert property (sMul ##0 oldByte == 1 |-> ##2 outQ == $past(dataByte, 2))
    else $error("unit product");
  AST_G0: assert property (sOne(2'h0) ##0 dataPos == 0 |-> ##2 outQ == $past(dataByte, 2))
    else $error("weight one");
  AST_G3: assert property (sOne(2'h0) ##0 dataPos == 3 && dataByte == 1 |-> ##2 outQ == 8'h08)
    else $error("weight eight");
  AST_P: assert property (sOne(2'h0) |-> ##2 outValid && outP == $past(dataByte, 2))
    else $error("p term");
  AST_RG: assert property (sOne(2'h2) |-> ##2 outP == $past(dataByte, 2))
    else $error("rebuild");
  AST_PE: assert property (sOne(2'h0) |-> ##2
    posError == ($past(dataPos, 2) > rpq_pkg::MAX_DATA_POS))
    else $error("pos flag");
  AST_COLLAT: assert property (sColEnd |-> ##2 outValid)
    else $error("column result late");
  AST_UPDP: assert property (sUpd |-> ##2
    outP == ($past(oldP, 2) ^ $past(oldByte, 2) ^ $past(dataByte, 2)))
    else $error("update p");
endmodule
bind rpq_parity_engine rpq_engine_sva rpq_engine_sva_inst (
  .ref_clk   (ref_clk),
  .srst      (srst),
  .inValid   (inValid),
  .opCode    (opCode),
  .firstByte (firstByte),
  .lastByte  (lastByte),
  .dataPos   (dataPos),
  .dataByte  (dataByte),
  .oldByte   (oldByte),
  .oldP      (oldP),
  .outValid  (outValid),
  .outP      (outP),
  .outQ      (outQ),
  .posError  (posError)
);

// ### rpq_result_sink.sv
/* buffer-side sink: stores the first 32 results.
   assumes results are one-cycle pulses */
`timescale 1ns/1ps
module rpq_result_sink (
  input wire logic       ref_clk,  // clk
  input wire logic       srst,     // rst
  input wire logic       outValid, // pulse
  input wire logic [7:0] outP,     // p
  input wire logic [7:0] outQ,     // q
  input wire logic       posError, // err
  output int             count     // results
);
  logic [16:0] cap [0:31];
  always_ff @(posedge ref_clk) begin
    if (srst) count <= 0;
    else if (outValid) begin
      cap[count] <= {posError, outP, outQ};
      count <= count + 1;
    end
  end
endmodule

// ### tb_top.sv
/* testbench for the parity engine.
   assumes checker bound and sink beside */
`timescale 1ns/1ps
module tb_top;
  logic       ref_clk = 0, srst = 1, inValid = 0, firstByte = 0, lastByte = 0;
  logic [1:0] opCode = 0;
  logic [7:0] dataPos = 0, dataByte = 0, oldByte = 0, oldP = 0, oldQ = 0;
  logic       inReady, outValid, posError;
  logic [7:0] outP, outQ;
  int         count, nx = 0, bad_count = 0, total_checks = 0;
  always #2 ref_clk = ~ref_clk;
  rpq_parity_engine rpq_parity_engine_inst (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .inValid   (inValid),
    .inReady   (inReady),
    .opCode    (opCode),
    .firstByte (firstByte),
    .lastByte  (lastByte),
    .dataPos   (dataPos),
    .dataByte  (dataByte),
    .oldByte   (oldByte),
    .oldP      (oldP),
    .oldQ      (oldQ),
    .outValid  (outValid),
    .outP      (outP),
    .outQ      (outQ),
    .posError  (posError)
  );
  rpq_result_sink rpq_result_sink_inst (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .outValid  (outValid),
    .outP      (outP),
    .outQ      (outQ),
    .posError  (posError),
    .count     (count)
  );
  function automatic logic [7:0] gm(logic [7:0] a, b);
    logic [8:0] x;
    logic [7:0] r;
    r = 0;
    x = {1'b0, a};
    for (int i = 0; i < 8; i++) begin
      if (b[i]) r ^= x[7:0];
      x = x << 1;
      if (x[8]) x ^= rpq_pkg::FIELD_POLY;
    end
    return r;
  endfunction
  task automatic drv(logic [1:0] op, fl, logic [7:0] pos, d, o);
    @(negedge ref_clk);
    inValid = 1;
    opCode = op;
    {firstByte, lastByte} = fl;
    dataPos = pos;
    dataByte = d;
    oldByte = o;
  endtask
  task automatic idle();
    @(negedge ref_clk);
    inValid = 0;
  endtask
  task automatic chk(logic [16:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // q is masked where its meaning is open
  task automatic res(logic e, logic [7:0] p, q, logic qOn = 1);
    for (int i = 0; i < 20 && count <= nx; i++) @(negedge ref_clk);
    chk(rpq_result_sink_inst.cap[nx] & {9'h1FF, {8{qOn}}}, {e, p, q & {8{qOn}}});
    nx++;
  endtask
  task automatic t_gen();
    drv(2'h0, 2'h2, 8'h02, 8'h5A, 8'h00);
    drv(2'h0, 2'h0, 8'h00, 8'hC3, 8'h00);
    drv(2'h0, 2'h1, 8'h01, 8'h17, 8'h00);
    drv(2'h0, 2'h3, 8'h03, 8'h01, 8'h00);
    idle();
    res(0, 8'h5A ^ 8'hC3 ^ 8'h17, gm(4, 8'h5A) ^ 8'hC3 ^ gm(2, 8'h17));
    res(0, 8'h01, 8'h08);
  endtask
  task automatic t_upd();
    oldP = 8'h3C;
    oldQ = 8'h99;
    drv(2'h1, 2'h0, 8'h01, 8'hA5, 8'h4E);
    drv(2'h1, 2'h0, 8'h00, 8'h11, 8'h11);
    idle();
    res(0, 8'h3C ^ 8'h4E ^ 8'hA5, 8'h99 ^ gm(2, 8'h4E ^ 8'hA5));
    res(0, 8'h3C, 8'h99);
  endtask
  task automatic t_mul();
    logic [7:0] a [5] = '{8'h00, 8'h02, 8'hB7, 8'hFF, 8'h9C};
    logic [7:0] b [5] = '{8'h53, 8'h08, 8'h01, 8'hFF, 8'h00};
    for (int i = 0; i < 5; i++) drv(2'h3, 2'h0, 8'h00, a[i], b[i]);
    idle();
    for (int i = 0; i < 5; i++) res(0, a[i] ^ b[i], gm(a[i], b[i]));
  endtask
  task automatic t_rgn();
    drv(2'h2, 2'h2, 8'h00, 8'h6D, 8'h00);
    drv(2'h2, 2'h1, 8'h09, 8'h28, 8'h00);
    drv(2'h0, 2'h3, 8'hFC, 8'h07, 8'h00);
    drv(2'h0, 2'h3, 8'hFD, 8'h07, 8'h00);
    idle();
    res(0, 8'h6D ^ 8'h28, 0, 0);
    res(0, 8'h07, 0, 0);
    res(1, 8'h07, 0, 0);
  endtask
  // lost data and lost Q: rebuild the data first, then Q from the full set
  task automatic t_dual();
    drv(2'h2, 2'h2, 8'h01, 8'h21, 8'h00);
    drv(2'h2, 2'h0, 8'h02, 8'h42, 8'h00);
    drv(2'h2, 2'h1, 8'h00, 8'h7E ^ 8'h21 ^ 8'h42, 8'h00);
    drv(2'h0, 2'h2, 8'h00, 8'h7E, 8'h00);
    drv(2'h0, 2'h0, 8'h01, 8'h21, 8'h00);
    drv(2'h0, 2'h1, 8'h02, 8'h42, 8'h00);
    idle();
    res(0, 8'h7E, 0, 0);
    res(0, 8'h7E ^ 8'h21 ^ 8'h42, 8'h7E ^ gm(2, 8'h21) ^ gm(4, 8'h42));
  endtask
  // reset cuts an open column; the next columns must start clean
  task automatic t_rst();
    drv(2'h0, 2'h2, 8'h00, 8'h55, 8'h00);
    idle();
    srst = 1;
    repeat (2) @(negedge ref_clk);
    chk({posError, outP, outQ}, 17'h00000);
    chk({15'h0000, outValid, inReady}, 17'h00001);
    srst = 0;
    nx = 0;
    drv(2'h2, 2'h3, 8'h00, 8'h3E, 8'h00);
    drv(2'h0, 2'h3, 8'h00, 8'h9C, 8'h00);
    idle();
    res(0, 8'h3E, 0, 0);
    res(0, 8'h9C, 8'h9C);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk) srst = 0;
    t_gen();
    t_upd();
    t_mul();
    t_rgn();
    t_dual();
    t_rst();
    finish_test();
  end
  initial begin
    #4000;
    bad_count++;
    finish_test();
  end
endmodule
